// >>> logic/rcl_top.sv
// Reset cause logic: reset sequencing, cause flags, AXI4-Lite registers
// ****************************************************************
// Summary of operation
// - Five reset sources are accepted: power-on, clear running, clear asleep, watchdog running, watchdog asleep.
// - Registers outside reset keep their value on every reset except power-on, where they are undefined.
// - Ordinary registers take their reset values on power-on, master clear or watchdog reset.
// - A wake from sleep by master clear or watchdog performs a full reset, never a resume.
// - Status bits 4 and 3 record the reset cause so software can tell resets apart.
// - Master clear while running leaves both cause flags unchanged.
// - Master clear wake from sleep gives timeout flag 1 and power-down flag 0.
// - Watchdog reset while running gives timeout flag 0 and power-down flag 1.
// - Watchdog wake from sleep clears both cause flags.
// - Status is 8 bits at 03h: page select 7:5, cause flags 4:3, zero, digit carry, carry 2:0.
// - Power-on loads status with page select 0, both cause flags 1, low flags undefined.
// - Clear or watchdog reset zeroes page select, loads cause flags except on clear while running, keeps low flags.
// - In RC mode the oscillator output runs at a quarter of the core clock.
// ****************************************************************
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rcl_top
    import rcl_pkg::*;
#(
    parameter int HOLD = RCL_HOLD_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire rcl_pkg::rcl_req_s req,
    input  wire logic        rc_mode,
    input  wire logic        core_flag_we,
    input  wire logic [7:0]  core_flag_wdata,
    output var  logic        core_reset_n,
    output var  logic [7:0]  core_status_flags,
    output var  logic        oscillator_output,
    output var  logic        irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import rcl_pkg::*;

    // ****************************************************************
    // Request capture
    // ****************************************************************
    logic       master_clear_n;
    logic       master_clear_n_prev_q;
    logic       wdt_prev_q;
    rcl_cause_e cause;
    logic [7:0] hold_q;
    logic [4:0] event_q;
    logic [4:0] mask_q;
    logic [7:0] scratch_q;
    logic [1:0] div_q;
    logic       rd_clr;

    // Pin is asynchronous, so it passes two flops first
    rcl_sync #(.RST_VAL(1'b1)) i_rcl_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       (req.master_clear_n),
        .q       (master_clear_n)
    );

    // Falling edge of clear and rising edge of timeout start a reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_clear_n_prev_q <= 1'b1;
            wdt_prev_q  <= 1'b0;
        end else if (ce) begin
            master_clear_n_prev_q <= master_clear_n;
            wdt_prev_q  <= req.wdt_timeout;
        end
    end

    // Decode of the cause; power-on outranks clear, clear outranks watchdog
    always_comb begin
        cause = RCL_CAUSE_NONE;
        if (req.por)
            cause = RCL_CAUSE_POR;
        else if (!master_clear_n && master_clear_n_prev_q)
            cause = req.asleep ? RCL_CAUSE_MASTER_CLEAR_N_W : RCL_CAUSE_MASTER_CLEAR_N;
        else if (req.wdt_timeout && !wdt_prev_q)
            cause = req.asleep ? RCL_CAUSE_WDT_W : RCL_CAUSE_WDT;
    end

    // ****************************************************************
    // Reset generation
    // ****************************************************************
    // Held while clear stays low; released on a clock edge only
    // Counter stops at zero, so a long quiet spell cannot wrap it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q       <= 8'(HOLD);
            core_reset_n <= 1'b0;
        end else if (ce) begin
            if (cause != RCL_CAUSE_NONE || !master_clear_n)
                hold_q <= 8'(HOLD);
            else if (hold_q != 8'h00)
                hold_q <= hold_q - 8'h01;
            core_reset_n <= (hold_q == 8'h00) && master_clear_n
                            && (cause == RCL_CAUSE_NONE);
        end
    end

    // ****************************************************************
    // Status register
    // ****************************************************************
    // Low flags are not touched by clear or watchdog, so software keeps them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_status_flags <= RCL_STATUS_POR;
        end else if (ce) begin
            case (cause)
                RCL_CAUSE_POR:
                    core_status_flags <= RCL_STATUS_POR;
                RCL_CAUSE_MASTER_CLEAR_N: begin
                    core_status_flags[7:5] <= 3'h0;
                end // cause flags left alone
                RCL_CAUSE_MASTER_CLEAR_N_W: begin
                    core_status_flags[7:5] <= 3'h0;
                    core_status_flags[RCL_BIT_TO] <= 1'b1;
                    core_status_flags[RCL_BIT_PD] <= 1'b0;
                end
                RCL_CAUSE_WDT: begin
                    core_status_flags[7:5] <= 3'h0;
                    core_status_flags[RCL_BIT_TO] <= 1'b0;
                    core_status_flags[RCL_BIT_PD] <= 1'b1;
                end
                RCL_CAUSE_WDT_W: begin
                    core_status_flags[7:5] <= 3'h0;
                    core_status_flags[RCL_BIT_TO] <= 1'b0;
                    core_status_flags[RCL_BIT_PD] <= 1'b0;
                end
                default: begin
                    // Core updates page select and arithmetic flags only
                    if (core_flag_we && core_reset_n) begin
                        core_status_flags[7:5] <= core_flag_wdata[7:5];
                        core_status_flags[2:0] <= core_flag_wdata[2:0];
                    end
                end
            endcase
        end
    end

    // Scratch word stands for a register outside reset: of the resets only power-on
    // touches it, and then to an arbitrary value; writes to the control word load it
    always_ff @(posedge aclk) begin
        if (ce) begin
            if (cause == RCL_CAUSE_POR)
                scratch_q <= 8'h00;
            else if (s_axi_awvalid && s_axi_wvalid && s_axi_awready
                     && s_axi_awaddr == RCL_CTRL_ADDR && s_axi_wstrb[1])
                scratch_q <= s_axi_wdata[15:8];
        end
    end

    // ****************************************************************
    // Quarter rate clock output
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q             <= 2'h0;
            oscillator_output <= 1'b0;
        end else if (ce) begin
            div_q <= div_q + 2'h1;
            oscillator_output <= rc_mode & div_q[1];
        end
    end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    // Set beats the clear from a read in the same cycle
    logic [4:0] ev_set;
    logic [4:0] ev_clr;
    // One bit per cause; a read clears only the bits it returned, so an
    // event landing between snapshot and clear is not lost
    always_comb begin
        ev_set = 5'h00;
        if (cause != RCL_CAUSE_NONE)
            ev_set[3'(cause) - 3'd1] = 1'b1;
        ev_clr = rd_clr ? s_axi_rdata[4:0] : 5'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= RCL_EVENT_RST;
        end else if (ce) begin
            event_q <= (event_q & ~ev_clr) | ev_set;
        end
    end

    // Registered so the pin never glitches while mask and events settle
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq <= 1'b0;
        else if (ce)
            irq <= |(event_q & mask_q);
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // Takes address and data together; one write in flight at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RCL_AXI_OKAY;
            mask_q        <= RCL_MASK_RST;
        end else if (ce) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Response only once both channels have completed their handshake
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bresp   <= RCL_AXI_OKAY;
                case (s_axi_awaddr)
                    RCL_MASK_ADDR:
                        if (s_axi_wstrb[0]) mask_q <= s_axi_wdata[4:0];
                    RCL_CTRL_ADDR, RCL_STATUS_ADDR, RCL_EVENT_ADDR: ;
                    default: s_axi_bresp <= RCL_AXI_SLVERR;
                endcase
            end
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RCL_AXI_OKAY;
            rd_clr        <= 1'b0;
        end else if (ce) begin
            s_axi_arready <= 1'b0;
            rd_clr        <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            // Data valid only after the address handshake has completed
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end else if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rresp   <= RCL_AXI_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                case (s_axi_araddr)
                    RCL_STATUS_ADDR: s_axi_rdata[7:0] <= core_status_flags;
                    RCL_CTRL_ADDR:   s_axi_rdata[15:8] <= scratch_q;
                    RCL_EVENT_ADDR: begin
                        s_axi_rdata[4:0] <= event_q;
                        rd_clr           <= 1'b1;
                    end
                    RCL_MASK_ADDR:   s_axi_rdata[4:0] <= mask_q;
                    default:         s_axi_rresp <= RCL_AXI_SLVERR;
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_master_clear_n_wake_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_MASTER_CLEAR_N_W |=> core_status_flags[4:3] == 2'b10)
        else $error("clear wake flags wrong");
    a_wdt_run_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_WDT |=> core_status_flags[4:3] == 2'b01)
        else $error("watchdog run flags wrong");
    a_wdt_wake_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_WDT_W |=> core_status_flags[4:3] == 2'b00)
        else $error("watchdog wake flags wrong");
    a_master_clear_n_run_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_MASTER_CLEAR_N |=> $stable(core_status_flags[4:0]))
        else $error("clear run changed flags");
    a_por_value: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_POR |=> core_status_flags[7:3] == 5'b00011)
        else $error("power-on value wrong");
    a_page_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause != RCL_CAUSE_NONE |=> core_status_flags[7:5] == 3'h0)
        else $error("page select not cleared");
    a_reset_asserts: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause != RCL_CAUSE_NONE |=> !core_reset_n)
        else $error("core not reset");
    // Clock output: once running, it changes every second cycle
    a_clock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && rc_mode) [*3] ##0 $changed(oscillator_output)
        |=> $stable(oscillator_output))
        else $error("quarter clock changed twice in a row");
    a_clock_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && rc_mode) [*3] ##0 $stable(oscillator_output)
        |=> $changed(oscillator_output))
        else $error("quarter clock held too long");

    // ****************************************************************
    // Reset and event checks
    // ****************************************************************
    a_held_while_low: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !master_clear_n |=> !core_reset_n)
        else $error("core released while clear low");
    a_release_on_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(core_reset_n) |-> $past(master_clear_n) && $past(hold_q) == 8'h00)
        else $error("core released early");
    a_wake_full_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && req.asleep && cause != RCL_CAUSE_NONE |=> !core_reset_n && hold_q == 8'(HOLD))
        else $error("wake did not restart core");
    a_low_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause != RCL_CAUSE_NONE && cause != RCL_CAUSE_POR
        |=> $stable(core_status_flags[2:0]))
        else $error("low flags changed by reset");
    // Event bits: a cause always lands, even against a clearing read
    a_por_event: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_POR |=> event_q[0])
        else $error("power-on event lost");
    a_master_clear_n_event: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_MASTER_CLEAR_N |=> event_q[1])
        else $error("clear run event lost");
    a_master_clear_n_wake_event: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_MASTER_CLEAR_N_W |=> event_q[2])
        else $error("clear wake event lost");
    a_wdt_event: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_WDT |=> event_q[3])
        else $error("watchdog run event lost");
    a_wdt_wake_event: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cause == RCL_CAUSE_WDT_W |=> event_q[4])
        else $error("watchdog wake event lost");
endmodule : rcl_top
`default_nettype wire

// >>> logic/rcl_pkg.sv
// Package: constants and types for the reset cause logic
`default_nettype none
package rcl_pkg;
    // ****************************************************************
    // Register map (byte addresses on the register bus)
    // ****************************************************************
    localparam logic [7:0] RCL_STATUS_OFF   = 8'h03;  // core_status_flags index
    localparam logic [7:0] RCL_STATUS_ADDR  = 8'h0C;  // index times four
    localparam logic [7:0] RCL_CTRL_ADDR    = 8'h10;
    localparam logic [7:0] RCL_EVENT_ADDR   = 8'h14;
    localparam logic [7:0] RCL_MASK_ADDR    = 8'h18;
    // ****************************************************************
    // Field positions of core_status_flags
    // ****************************************************************
    localparam int RCL_BIT_TO = 4;
    localparam int RCL_BIT_PD = 3;
    // Reset values
    localparam logic [7:0] RCL_STATUS_POR   = 8'h18;  // 0001_1xxx, x taken as 0
    localparam logic [7:0] RCL_CTRL_RST     = 8'h00;
    localparam logic [4:0] RCL_EVENT_RST    = 5'h00;
    localparam logic [4:0] RCL_MASK_RST     = 5'h00;
    localparam logic [1:0] RCL_AXI_OKAY     = 2'h0;
    localparam logic [1:0] RCL_AXI_SLVERR   = 2'h2;
    // Reset hold length in core cycles
    localparam int RCL_HOLD_CYCLES = 4;
    localparam int RCL_CLK_DIV_HALF = 2;    // quarter rate output
    // Reset causes; the event bit number is the cause code minus one
    typedef enum logic [2:0] {
        RCL_CAUSE_NONE   = 3'b000,
        RCL_CAUSE_POR    = 3'b001,
        RCL_CAUSE_MASTER_CLEAR_N   = 3'b010,
        RCL_CAUSE_MASTER_CLEAR_N_W = 3'b011,
        RCL_CAUSE_WDT    = 3'b100,
        RCL_CAUSE_WDT_W  = 3'b101
    } rcl_cause_e;
    // Reset requests bundled together
    typedef struct packed {
        logic por;
        logic master_clear_n;
        logic wdt_timeout;
        logic asleep;
    } rcl_req_s;
endpackage : rcl_pkg
`default_nettype wire

// >>> logic/rcl_sync.sv
// Two flop synchroniser for the master clear pin
`timescale 1ns/100ps
`default_nettype none
module rcl_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic d,
    output var  logic q
);
    logic meta_q;
    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : rcl_sync
`default_nettype wire

// >>> dv/rcl_pin_model.sv
// Partner model: master clear pin and watchdog timeout source
`timescale 1ns/100ps
`default_nettype none
module rcl_pin_model #(
    parameter int LOW_CYCLES = 6
) (
    input  wire logic aclk,
    input  wire logic clear_cmd,
    input  wire logic wdt_cmd,
    output var  logic master_clear_n,
    output var  logic wdt_timeout
);
    int   low_cnt = 0;
    logic wdt_q   = 1'b0;
    // Pin held low well past the two flop synchroniser, high otherwise
    always @(posedge aclk) begin
        if (clear_cmd) low_cnt <= LOW_CYCLES;
        else if (low_cnt > 0) low_cnt <= low_cnt - 1;
    end
    assign master_clear_n = (low_cnt == 0);
    // One cycle timeout strobe; the design reacts to its rising edge
    always @(posedge aclk) wdt_q <= wdt_cmd;
    assign wdt_timeout = wdt_q;
endmodule : rcl_pin_model
`default_nettype wire

// >>> dv/rcl_top_bench.sv
// Testbench for the reset cause logic, driven over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module rcl_top_bench;
    import rcl_pkg::*;
    logic aclk, aresetn, ce, rc_mode, core_flag_we, por, asleep, clear_cmd, wdt_cmd;
    logic [7:0] core_flag_wdata, core_status_flags, awaddr, araddr;
    logic core_reset_n, oscillator_output, irq, pin_n, wdt;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    rcl_req_s    req;
    int          miscompares = 0;
    int          compares = 0;
    assign req = '{por: por, master_clear_n: pin_n, wdt_timeout: wdt, asleep: asleep};
    // ****************************************************************
    // Design and partner
    // ****************************************************************
    rcl_top #(.HOLD(4)) i_rcl_top (.aclk(aclk), .aresetn(aresetn), .ce(ce), .req(req),
        .rc_mode(rc_mode), .core_flag_we(core_flag_we), .core_flag_wdata(core_flag_wdata),
        .core_reset_n(core_reset_n), .core_status_flags(core_status_flags),
        .oscillator_output(oscillator_output), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    rcl_pin_model i_rcl_pin_model (.aclk(aclk), .clear_cmd(clear_cmd), .wdt_cmd(wdt_cmd),
        .master_clear_n(pin_n), .wdt_timeout(wdt));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic hang();
        miscompares++;
        final_report();
    endtask : hang
    // Each channel released only at the edge where its ready is seen
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
        @(posedge aclk);  // Lets an edge pass before the next request
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        int n;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rsp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
        @(posedge aclk);  // Lets an edge pass before the next request
    endtask : axi_read
    task automatic wait_core(input logic lvl);
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (core_reset_n === lvl) break;
        end
        if (n == 100) hang();
    endtask : wait_core
    // Clock, 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin : main
        logic [7:0] low_t [5] = '{8'hE5, 8'hA2, 8'h47, 8'hE1, 8'h26};
        bit wdt_t [5] = '{1, 0, 0, 1, 0};
        bit slp_t [5] = '{0, 0, 1, 1, 0};
        int ev_t [5] = '{3, 1, 2, 4, 1};
        logic to_e, pd_e, last;
        int tog;
        aresetn = 0; ce = 1; por = 1; asleep = 0; rc_mode = 0; core_flag_we = 0;
        core_flag_wdata = 8'h00; clear_cmd = 0; wdt_cmd = 0; awaddr = 8'h00; araddr = 8'h00;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        wdata = 32'h0; wstrb = 4'hF; to_e = 1; pd_e = 1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        por <= 1'b0;
        wait_core(1'b1);
        axi_read(RCL_STATUS_ADDR); check(rd, 32'h0000_0018);
        axi_read(RCL_EVENT_ADDR); check(rd, 32'h0000_0001);
        axi_write(RCL_MASK_ADDR, 32'h0000_001F); check({30'h0, rsp}, 32'h0);
        axi_read(RCL_MASK_ADDR); check(rd, 32'h0000_001F);
        axi_write(RCL_CTRL_ADDR, 32'h0000_A500);
        // Every clear and watchdog cause in turn, with distinct low flags each time
        for (int i = 0; i < 5; i++) begin
            core_flag_we <= 1'b1; core_flag_wdata <= low_t[i];
            @(posedge aclk);
            core_flag_we <= 1'b0;
            axi_read(RCL_STATUS_ADDR);
            check(rd, {24'h0, low_t[i][7:5], to_e, pd_e, low_t[i][2:0]});
            asleep <= slp_t[i];
            if (wdt_t[i]) wdt_cmd <= 1'b1;
            else clear_cmd <= 1'b1;
            @(posedge aclk);
            wdt_cmd <= 1'b0; clear_cmd <= 1'b0;
            wait_core(1'b0);
            wait_core(1'b1);
            asleep <= 1'b0;
            if (wdt_t[i] || slp_t[i]) begin
                to_e = !wdt_t[i];
                pd_e = !slp_t[i];
            end
            axi_read(RCL_STATUS_ADDR);
            check(rd, {27'h0, to_e, pd_e, low_t[i][2:0]});
            check({31'h0, irq}, {31'h0, i == 0});
            axi_read(RCL_EVENT_ADDR); check(rd, 32'h1 << ev_t[i]);
            repeat (2) @(posedge aclk);
            check({31'h0, irq}, 32'h0);
            if (i == 0) axi_write(RCL_MASK_ADDR, 32'h0);
        end
        axi_read(RCL_CTRL_ADDR); check({24'h0, rd[15:8]}, 32'h0000_00A5);
        // Refused accesses to unmapped places, and a write that the read-only status word answers OKAY but ignores
        axi_read(8'h40); check({30'h0, rsp}, {30'h0, RCL_AXI_SLVERR});
        axi_write(8'h44, 32'h1); check({30'h0, rsp}, {30'h0, RCL_AXI_SLVERR});
        axi_write(RCL_STATUS_ADDR, 32'hFF);
        axi_read(RCL_STATUS_ADDR); check(rd, {27'h0, to_e, pd_e, low_t[4][2:0]});
        // Quarter rate clock: a toggle every second cycle
        rc_mode <= 1'b1;
        repeat (4) @(posedge aclk);
        tog = 0;
        last = oscillator_output;
        repeat (16) begin
            @(posedge aclk);
            if (oscillator_output !== last) tog++;
            last = oscillator_output;
        end
        check(tog, 32'd8);
        // Clock enable low freezes the divider and its output
        ce <= 1'b0;
        @(posedge aclk);
        last = oscillator_output;
        repeat (6) @(posedge aclk);
        check({31'h0, oscillator_output}, {31'h0, last});
        ce <= 1'b1;
        rc_mode <= 1'b0;
        repeat (4) @(posedge aclk);
        check({31'h0, oscillator_output}, 32'h0);
        final_report();
    end
endmodule : rcl_top_bench
`default_nettype wire
